// [bench/tb_top.sv]
// self-checking bench for the error status record block
// assumes resr_pkg is compiled first; bench is the axi4-lite master and error source
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [5:0] e1;
    logic [5:0] e2;
    logic wr;
    logic [31:0] wd;
    logic [31:0] ex;
    logic [31:0] mk;
  } resr_row_t;
  // type field left open for deferred or corrected only records
  localparam logic [31:0] MK = 32'h7bf0_0000;
  localparam logic [31:0] MN = 32'h7bc0_0000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] awaddr = 16'h0;
  logic [15:0] araddr = 16'h0;
  logic [2:0] awprot = 3'h0;
  logic [2:0] arprot = 3'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [5:0] ev = 6'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int error_cnt = 0;
  int n_compared = 0;
  resr_row_t rows [20];
  logic [31:0] d;
  logic [1:0] r;

  always #5 aclk = ~aclk;

  resr_top i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axil_awaddr(awaddr), .s_axil_awprot(awprot), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb),
    .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
    .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
    .s_axil_arprot(arprot), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
    .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
    .s_axil_rready(rready), .err_uncorrected(ev[0]), .err_uncontainable(ev[1]),
    .err_deferred(ev[2]), .err_corrected(ev[3]), .err_poison(ev[4]),
    .err_abort(ev[5]), .irq(irq)
  );

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      error_cnt++;
    end
  endtask

  task automatic hang();
    $display("[FAIL] bus wait expected answer seen none");
    error_cnt++;
    complete_run();
  endtask

  // called just after a rising edge; payload held until each ready
  task automatic axw(input logic [15:0] a, input logic [31:0] dv, input logic ns);
    int i;
    awaddr <= a;
    awprot <= {1'b0, ns, 1'b0};
    awvalid <= 1'b1;
    wdata <= dv;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 40) hang();
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axr(input logic [15:0] a, input logic ns);
    int i;
    araddr <= a;
    arprot <= {1'b0, ns, 1'b0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 40) hang();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic pulse(input logic [5:0] e);
    ev <= e;
    @(posedge aclk);
    ev <= 6'h0;
    @(posedge aclk);
  endtask

  // sync reset held six edges; requests start one edge after release
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic wirq(input logic v);
    for (int i = 0; i < 8; i++) begin
      if (irq === v) break;
      @(posedge aclk);
    end
    chk("irq", 32'(v), 32'(irq));
  endtask

  initial begin
    // e bits: 0 unc, 1 uncontainable, 2 def, 3 corr, 4 poison, 5 abort
    rows[0] = '{6'h01, 6'h00, 1'b0, 32'h0, 32'h6030_0000, MK};
    rows[1] = '{6'h03, 6'h00, 1'b0, 32'h0, 32'h6000_0000, MK};
    rows[2] = '{6'h31, 6'h00, 1'b0, 32'h0, 32'h7070_0000, MK};
    rows[3] = '{6'h01, 6'h01, 1'b0, 32'h0, 32'h6830_0000, MK};
    rows[4] = '{6'h04, 6'h04, 1'b0, 32'h0, 32'h4880_0000, MN};
    rows[5] = '{6'h01, 6'h04, 1'b0, 32'h0, 32'h68b0_0000, MK};
    rows[6] = '{6'h04, 6'h08, 1'b0, 32'h0, 32'h4a80_0000, MN};
    rows[7] = '{6'h08, 6'h08, 1'b0, 32'h0, 32'h4a00_0000, MN};
    rows[8] = '{6'h08, 6'h00, 1'b0, 32'h0, 32'h4200_0000, MN};
    rows[9] = '{6'h08, 6'h00, 1'b1, 32'h0100_0000, 32'h4200_0000, MN};
    rows[10] = '{6'h08, 6'h00, 1'b1, 32'h0300_0000, 32'h4000_0000, MN};
    rows[11] = '{6'h01, 6'h00, 1'b1, 32'h4000_0000, 32'h6030_0000, MK};
    rows[12] = '{6'h01, 6'h00, 1'b1, 32'h6000_0000, 32'h0, MK};
    rows[13] = '{6'h01, 6'h01, 1'b1, 32'h2000_0000, 32'h6830_0000, MK};
    rows[14] = '{6'h01, 6'h01, 1'b1, 32'h2800_0000, 32'h4030_0000, MK};
    rows[15] = '{6'h04, 6'h04, 1'b1, 32'h0080_0000, 32'h4880_0000, MN};
    rows[16] = '{6'h04, 6'h04, 1'b1, 32'h0880_0000, 32'h4000_0000, MN};
    rows[17] = '{6'h08, 6'h08, 1'b1, 32'h0300_0000, 32'h4a00_0000, MN};
    rows[18] = '{6'h01, 6'h01, 1'b1, 32'h0, 32'h6830_0000, MK};
    rows[19] = '{6'h31, 6'h00, 1'b1, 32'h1040_0000, 32'h7070_0000, MK};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(resr_pkg::ADDR_STATUS, 1'b0);
    chk("status reset", resr_pkg::STATUS_RESET, d);
    axr(resr_pkg::ADDR_IRQ_ENABLE, 1'b0);
    chk("irq enable reset", 32'h0, d);
    $display("test reset done");
    foreach (rows[k]) begin
      do_reset();
      pulse(rows[k].e1);
      pulse(rows[k].e2);
      if (rows[k].wr) axw(resr_pkg::ADDR_STATUS, rows[k].wd, 1'b0);
      axr(resr_pkg::ADDR_STATUS, 1'b0);
      chk($sformatf("status row %0d", k), rows[k].ex & rows[k].mk, d & rows[k].mk);
    end
    $display("test table done");
    // error held high across the clear write: the set must survive
    do_reset();
    pulse(6'h01);
    ev <= 6'h01;
    axw(resr_pkg::ADDR_STATUS, 32'h6000_0000, 1'b0);
    ev <= 6'h00;
    axr(resr_pkg::ADDR_STATUS, 1'b0);
    chk("set over clear", 32'h6000_0000, d & 32'h6000_0000);
    $display("test set priority done");
    // nonsecure access gated by the access control bit
    do_reset();
    pulse(6'h01);
    axr(resr_pkg::ADDR_STATUS, 1'b1);
    chk("ns read", 32'h0, d);
    chk("ns read resp", 32'(resr_pkg::RESP_OKAY), 32'(r));
    axw(resr_pkg::ADDR_STATUS, 32'h6000_0000, 1'b1);
    axr(resr_pkg::ADDR_STATUS, 1'b0);
    chk("ns write dropped", 32'h6030_0000, d & MK);
    axw(resr_pkg::ADDR_ACCESS_CTRL, 32'h1, 1'b0);
    axr(resr_pkg::ADDR_STATUS, 1'b1);
    chk("ns read allowed", 32'h6030_0000, d & MK);
    axr(16'h8e94, 1'b0);
    chk("unmapped read", 32'(resr_pkg::RESP_SLVERR), 32'(r));
    axw(16'h8e94, 32'hffff_ffff, 1'b0);
    chk("unmapped write", 32'(resr_pkg::RESP_SLVERR), 32'(r));
    do_reset();
    axr(resr_pkg::ADDR_STATUS, 1'b0);
    chk("status after rerun reset", 32'h0, d);
    $display("test access done");
    // interrupt raise, mask, unmask, clear
    axw(resr_pkg::ADDR_IRQ_ENABLE, 32'h1, 1'b0);
    pulse(6'h01);
    wirq(1'b1);
    axr(resr_pkg::ADDR_IRQ_STATUS, 1'b0);
    chk("irq status", 32'h1, d & 32'hf);
    axw(resr_pkg::ADDR_IRQ_ENABLE, 32'h0, 1'b0);
    wirq(1'b0);
    axw(resr_pkg::ADDR_IRQ_ENABLE, 32'h1, 1'b0);
    wirq(1'b1);
    axw(resr_pkg::ADDR_IRQ_CLEAR, 32'h1, 1'b0);
    wirq(1'b0);
    axr(resr_pkg::ADDR_IRQ_STATUS, 1'b0);
    chk("irq status cleared", 32'h0, d & 32'hf);
    $display("test interrupt done");
    complete_run();
  end
endmodule

// [design/resr_axil_wr.sv]
// axi4-lite write channel capture: holds address, data and strobes
// assumes the master keeps valid and payload until taken
`timescale 1ns/1ps
module resr_axil_wr (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] awaddr,
  input wire logic awprot_ns,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  input wire logic done,
  output logic req,
  output logic [15:0] addr,
  output logic ns,
  output logic [31:0] data,
  output logic [3:0] strb
);
  logic have_a, have_d, next_have_a, next_have_d;
  logic [15:0] next_addr;
  logic next_ns;
  logic [31:0] next_data;
  logic [3:0] next_strb;
  logic aw_open, w_open, next_aw_open, next_w_open;

  always_comb begin
    next_have_a = have_a;
    next_have_d = have_d;
    next_addr = addr;
    next_ns = ns;
    next_data = data;
    next_strb = strb;
    if (done) begin
      next_have_a = 1'b0;
      next_have_d = 1'b0;
    end else begin
      if (awvalid && awready) begin
        next_have_a = 1'b1;
        next_addr = awaddr;
        next_ns = awprot_ns;
      end
      if (wvalid && wready) begin
        next_have_d = 1'b1;
        next_data = wdata;
        next_strb = wstrb;
      end
    end
    next_aw_open = !next_have_a;
    next_w_open = !next_have_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_a <= 1'b0;
      have_d <= 1'b0;
      addr <= 16'h0;
      ns <= 1'b0;
      data <= 32'h0;
      strb <= 4'h0;
      aw_open <= 1'b0;
      w_open <= 1'b0;
    end else begin
      have_a <= next_have_a;
      have_d <= next_have_d;
      addr <= next_addr;
      ns <= next_ns;
      data <= next_data;
      strb <= next_strb;
      aw_open <= next_aw_open;
      w_open <= next_w_open;
    end
  end

  // ready from a flop, low in reset; open only while the slot is empty
  assign awready = aw_open;
  assign wready = w_open;
  assign req = have_a && have_d;
endmodule

// [design/resr_irq.sv]
// sticky interrupt status with enable and write-one-to-clear
// assumes events are one-cycle pulses on the same clock
`timescale 1ns/1ps
module resr_irq (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] events,
  input wire logic [3:0] clear,
  input wire logic enable_we,
  input wire logic [3:0] enable_wdata,
  output logic [3:0] status,
  output logic [3:0] enable,
  output logic irq
);
  logic [3:0] next_status, next_enable;
  logic next_irq;

  always_comb begin
    // set beats clear so an event in the clearing cycle survives
    next_status = (status & ~clear) | events;
    next_enable = enable_we ? enable_wdata : enable;
    next_irq = |(next_status & next_enable);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= 4'h0;
      enable <= 4'h0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      enable <= next_enable;
      irq <= next_irq;
    end
  end
endmodule

// [design/resr_pkg.sv]
// constants for the error status record block
// assumes an axi4-lite slave with 32-bit data on a single clock
package resr_pkg;
  localparam logic [15:0] ADDR_STATUS = 16'h8e90;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'h8ea0;
  localparam logic [15:0] ADDR_IRQ_ENABLE = 16'h8ea4;
  localparam logic [15:0] ADDR_IRQ_CLEAR = 16'h8ea8;
  localparam logic [15:0] ADDR_ACCESS_CTRL = 16'h8eb0;
  localparam int BIT_VALID = 30;
  localparam int BIT_UNFIXED = 29;
  localparam int BIT_ABORT = 28;
  localparam int BIT_OVERFLOW = 27;
  localparam int BIT_CE_HI = 25;
  localparam int BIT_CE_LO = 24;
  localparam int BIT_POSTPONED = 23;
  localparam int BIT_POISON = 22;
  localparam int BIT_TYPE_HI = 21;
  localparam int BIT_TYPE_LO = 20;
  localparam logic [1:0] CE_NONE = 2'h0;
  localparam logic [1:0] CE_SOME = 2'h2;
  localparam logic [1:0] CE_CLEAR = 2'h3;
  localparam logic [1:0] TYPE_UNCONTAINABLE = 2'h0;
  localparam logic [1:0] TYPE_RECOVERABLE = 2'h3;
  localparam logic [31:0] STATUS_RESET = 32'h0;
  localparam int IRQ_UNFIXED = 0;
  localparam int IRQ_POSTPONED = 1;
  localparam int IRQ_CORRECTED = 2;
  localparam int IRQ_OVERFLOW = 3;
  localparam int IRQ_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic ACCESS_RESET = 1'b0;
endpackage

// [design/resr_top.sv]
// error status record with axi4-lite register access and interrupt
// assumes error sources pulse on aclk; awprot[1]/arprot[1] mark nonsecure
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module resr_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axil_awaddr,
  input wire logic [2:0] s_axil_awprot,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [15:0] s_axil_araddr,
  input wire logic [2:0] s_axil_arprot,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic err_uncorrected,
  input wire logic err_uncontainable,
  input wire logic err_deferred,
  input wire logic err_corrected,
  input wire logic err_poison,
  input wire logic err_abort,
  output logic irq
);
  logic wr_req, wr_ns, wr_done;
  logic [15:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic valid, unfixed, abort_signaled, overflow_flag, postponed_flag, poison_flag;
  logic [1:0] corrected, uncorrected_type;
  logic nonsecure_reliability_access;
  logic next_valid, next_unfixed, next_abort, next_overflow, next_postponed, next_poison;
  logic [1:0] next_corrected, next_uncorrected_type;
  logic next_access;
  logic [1:0] next_bresp, next_rresp;
  logic next_bvalid, next_rvalid, next_arready;
  logic [31:0] next_rdata;
  logic [3:0] irq_status, irq_enable, irq_clear, irq_events;
  logic irq_en_we;
  logic sw_ok, st_we, wr_busy;

  function automatic logic [31:0] status_word(input logic v, input logic ufx, input logic abt,
    input logic ofl, input logic [1:0] ce, input logic pst, input logic psn,
    input logic [1:0] ty);
    logic [31:0] w;
    w = 32'h0;
    w[resr_pkg::BIT_VALID] = v;
    w[resr_pkg::BIT_UNFIXED] = ufx;
    w[resr_pkg::BIT_ABORT] = abt;
    w[resr_pkg::BIT_OVERFLOW] = ofl;
    w[resr_pkg::BIT_CE_HI:resr_pkg::BIT_CE_LO] = ce;
    w[resr_pkg::BIT_POSTPONED] = pst;
    w[resr_pkg::BIT_POISON] = psn;
    w[resr_pkg::BIT_TYPE_HI:resr_pkg::BIT_TYPE_LO] = ty;
    return w;
  endfunction

  resr_axil_wr u_wr (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axil_awaddr),
    .awprot_ns(s_axil_awprot[1]),
    .awvalid(s_axil_awvalid),
    .awready(s_axil_awready),
    .wdata(s_axil_wdata),
    .wstrb(s_axil_wstrb),
    .wvalid(s_axil_wvalid),
    .wready(s_axil_wready),
    .done(wr_done),
    .req(wr_req),
    .addr(wr_addr),
    .ns(wr_ns),
    .data(wr_data),
    .strb(wr_strb)
  );

  // write acts once, in the cycle the response is raised
  assign wr_busy = s_axil_bvalid;
  assign wr_done = wr_req && !wr_busy;
  assign sw_ok = !wr_ns || nonsecure_reliability_access;
  assign st_we = wr_done && sw_ok && wr_addr == resr_pkg::ADDR_STATUS && (&wr_strb[3:2]);
  assign irq_en_we = wr_done && sw_ok && wr_addr == resr_pkg::ADDR_IRQ_ENABLE && wr_strb[0];
  assign irq_clear = (wr_done && sw_ok && wr_addr == resr_pkg::ADDR_IRQ_CLEAR && wr_strb[0]) ?
    wr_data[3:0] : 4'h0;

  // record update
  always_comb begin
    logic clr_v, clr_uf, clr_of, clr_ce, clr_pp, of_kept;
    logic ce_upd;
    clr_v = 1'b0;
    clr_uf = 1'b0;
    clr_of = 1'b0;
    clr_ce = 1'b0;
    clr_pp = 1'b0;
    of_kept = 1'b0;
    ce_upd = 1'b0;
    next_valid = valid;
    next_unfixed = unfixed;
    next_abort = abort_signaled;
    next_overflow = overflow_flag;
    next_postponed = postponed_flag;
    next_poison = poison_flag;
    next_corrected = corrected;
    next_uncorrected_type = uncorrected_type;
    next_access = nonsecure_reliability_access;
    if (st_we) begin
      clr_of = wr_data[resr_pkg::BIT_OVERFLOW];
      of_kept = overflow_flag && !clr_of;
      clr_uf = wr_data[resr_pkg::BIT_UNFIXED] && !of_kept;
      clr_pp = wr_data[resr_pkg::BIT_POSTPONED] && !of_kept;
      clr_ce = wr_data[resr_pkg::BIT_CE_HI:resr_pkg::BIT_CE_LO] == resr_pkg::CE_CLEAR
        && !of_kept;
      // valid guarded by flags left standing after this write
      clr_v = wr_data[resr_pkg::BIT_VALID] && !((unfixed && !clr_uf) ||
        (postponed_flag && !clr_pp) || (corrected != resr_pkg::CE_NONE && !clr_ce));
    end
    if (clr_v) next_valid = 1'b0;
    if (clr_uf) next_unfixed = 1'b0;
    if (clr_pp) next_postponed = 1'b0;
    if (clr_ce) next_corrected = resr_pkg::CE_NONE;
    if (clr_of) next_overflow = 1'b0;
    if (clr_v) begin
      next_abort = 1'b0;
      next_poison = 1'b0;
      next_uncorrected_type = resr_pkg::TYPE_UNCONTAINABLE;
    end
    // hardware sets applied last so they win over clears
    ce_upd = err_corrected && corrected != resr_pkg::CE_NONE;
    if ((err_uncorrected && unfixed) ||
        (err_deferred && (postponed_flag || unfixed)) ||
        (err_corrected && (postponed_flag || unfixed || ce_upd))) begin
      next_overflow = 1'b1;
    end
    if (err_uncorrected) begin
      next_unfixed = 1'b1;
      if (!unfixed) begin
        // first uncorrected error owns the syndrome
        next_uncorrected_type = err_uncontainable ? resr_pkg::TYPE_UNCONTAINABLE :
          resr_pkg::TYPE_RECOVERABLE;
        next_poison = err_poison;
      end
    end
    if (err_deferred) begin
      next_postponed = 1'b1;
      if (!unfixed && !err_uncorrected) next_poison = err_poison;
    end
    if (err_corrected) next_corrected = resr_pkg::CE_SOME;
    if (err_abort) next_abort = 1'b1;
    if (err_uncorrected || err_deferred || err_corrected) next_valid = 1'b1;
    if (wr_done && !wr_ns && wr_addr == resr_pkg::ADDR_ACCESS_CTRL && wr_strb[0]) begin
      next_access = wr_data[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valid <= 1'b0;
      unfixed <= 1'b0;
      abort_signaled <= 1'b0;
      overflow_flag <= 1'b0;
      postponed_flag <= 1'b0;
      poison_flag <= 1'b0;
      corrected <= resr_pkg::CE_NONE;
      uncorrected_type <= resr_pkg::TYPE_UNCONTAINABLE;
      nonsecure_reliability_access <= resr_pkg::ACCESS_RESET;
    end else begin
      valid <= next_valid;
      unfixed <= next_unfixed;
      abort_signaled <= next_abort;
      overflow_flag <= next_overflow;
      postponed_flag <= next_postponed;
      poison_flag <= next_poison;
      corrected <= next_corrected;
      uncorrected_type <= next_uncorrected_type;
      nonsecure_reliability_access <= next_access;
    end
  end

  assign irq_events = {next_overflow && !overflow_flag, err_corrected, err_deferred,
    err_uncorrected};

  resr_irq u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .events(irq_events),
    .clear(irq_clear),
    .enable_we(irq_en_we),
    .enable_wdata(wr_data[3:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(irq)
  );

  // bus responses; one outstanding of each kind
  always_comb begin
    logic rd_ok;
    logic is_map;
    rd_ok = !s_axil_arprot[1] || nonsecure_reliability_access;
    is_map = 1'b0;
    next_bvalid = s_axil_bvalid;
    next_bresp = s_axil_bresp;
    next_rvalid = s_axil_rvalid;
    next_rresp = s_axil_rresp;
    next_rdata = s_axil_rdata;
    if (s_axil_bvalid && s_axil_bready) next_bvalid = 1'b0;
    if (wr_done) begin
      next_bvalid = 1'b1;
      is_map = wr_addr == resr_pkg::ADDR_STATUS || wr_addr == resr_pkg::ADDR_IRQ_STATUS ||
        wr_addr == resr_pkg::ADDR_IRQ_ENABLE || wr_addr == resr_pkg::ADDR_IRQ_CLEAR ||
        wr_addr == resr_pkg::ADDR_ACCESS_CTRL;
      next_bresp = is_map ? resr_pkg::RESP_OKAY : resr_pkg::RESP_SLVERR;
    end
    if (s_axil_rvalid && s_axil_rready) next_rvalid = 1'b0;
    if (s_axil_arvalid && s_axil_arready) begin
      next_rvalid = 1'b1;
      next_rresp = resr_pkg::RESP_OKAY;
      unique case (s_axil_araddr)
        resr_pkg::ADDR_STATUS: next_rdata = rd_ok ? status_word(valid, unfixed,
          abort_signaled, overflow_flag, corrected, postponed_flag, poison_flag,
          uncorrected_type) : 32'h0;
        resr_pkg::ADDR_IRQ_STATUS: next_rdata = rd_ok ? {28'h0, irq_status} : 32'h0;
        resr_pkg::ADDR_IRQ_ENABLE: next_rdata = rd_ok ? {28'h0, irq_enable} : 32'h0;
        resr_pkg::ADDR_IRQ_CLEAR: next_rdata = 32'h0;
        resr_pkg::ADDR_ACCESS_CTRL: next_rdata = s_axil_arprot[1] ? 32'h0 :
          {31'h0, nonsecure_reliability_access};
        default: begin
          next_rdata = 32'h0;
          next_rresp = resr_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid && !(s_axil_arvalid && s_axil_arready);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= resr_pkg::RESP_OKAY;
      s_axil_rvalid <= 1'b0;
      s_axil_rresp <= resr_pkg::RESP_OKAY;
      s_axil_rdata <= 32'h0;
      s_axil_arready <= 1'b0;
    end else begin
      s_axil_bvalid <= next_bvalid;
      s_axil_bresp <= next_bresp;
      s_axil_rvalid <= next_rvalid;
      s_axil_rresp <= next_rresp;
      s_axil_rdata <= next_rdata;
      s_axil_arready <= next_arready;
    end
  end

  a_valid_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    (err_uncorrected || err_deferred || err_corrected) |=> valid)
    else $error("valid not set after error");
  a_valid_guard: assert property (@(posedge aclk) disable iff (!aresetn)
    (unfixed && !err_uncorrected && !(st_we && wr_data[resr_pkg::BIT_UNFIXED]))
    |=> valid)
    else $error("valid lost while unfixed stands");
  a_reset_clear: assert property (@(posedge aclk)
    !aresetn |=> !valid && !unfixed && !overflow_flag && corrected == resr_pkg::CE_NONE)
    else $error("record not cleared by reset");
  a_unfixed_set: assert property (@(posedge aclk) disable iff (!aresetn)
    err_uncorrected |=> unfixed)
    else $error("unfixed not set after error");
  a_unfixed_guard: assert property (@(posedge aclk) disable iff (!aresetn)
    (unfixed && overflow_flag && !(st_we && wr_data[resr_pkg::BIT_OVERFLOW]))
    |=> unfixed)
    else $error("unfixed cleared under overflow");
  a_abort_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    err_abort |=> abort_signaled)
    else $error("abort not recorded");
  a_abort_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (abort_signaled && !(st_we && wr_data[resr_pkg::BIT_VALID])) |=> abort_signaled)
    else $error("abort cleared by direct write");
  a_of_unfixed: assert property (@(posedge aclk) disable iff (!aresetn)
    (err_uncorrected && unfixed) |=> overflow_flag)
    else $error("overflow missed on second uncorrected");
  a_of_deferred: assert property (@(posedge aclk) disable iff (!aresetn)
    (err_deferred && (postponed_flag || unfixed)) |=> overflow_flag)
    else $error("overflow missed on deferred");
  a_of_corrected: assert property (@(posedge aclk) disable iff (!aresetn)
    (err_corrected && (postponed_flag || unfixed || corrected != resr_pkg::CE_NONE))
    |=> overflow_flag)
    else $error("overflow missed on corrected");
  a_of_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (overflow_flag && !(st_we && wr_data[resr_pkg::BIT_OVERFLOW])) |=> overflow_flag)
    else $error("overflow dropped without clear");
  a_ce_encode: assert property (@(posedge aclk) disable iff (!aresetn)
    corrected == resr_pkg::CE_NONE || corrected == resr_pkg::CE_SOME)
    else $error("corrected field reserved code");
  a_ce_clear_only: assert property (@(posedge aclk) disable iff (!aresetn)
    (corrected == resr_pkg::CE_SOME &&
    !(st_we && wr_data[resr_pkg::BIT_CE_HI:resr_pkg::BIT_CE_LO] == resr_pkg::CE_CLEAR))
    |=> corrected == resr_pkg::CE_SOME)
    else $error("corrected field cleared without clear code");
  a_ce_guard: assert property (@(posedge aclk) disable iff (!aresetn)
    (corrected == resr_pkg::CE_SOME && overflow_flag &&
    !(st_we && wr_data[resr_pkg::BIT_OVERFLOW])) |=> corrected == resr_pkg::CE_SOME)
    else $error("corrected field cleared under overflow");
  a_postponed_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (postponed_flag && !(st_we && wr_data[resr_pkg::BIT_POSTPONED])) |=> postponed_flag)
    else $error("postponed cleared without write");
  a_postponed_guard: assert property (@(posedge aclk) disable iff (!aresetn)
    (postponed_flag && overflow_flag && !(st_we && wr_data[resr_pkg::BIT_OVERFLOW]))
    |=> postponed_flag)
    else $error("postponed cleared under overflow");
  a_poison_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (poison_flag && !err_uncorrected && !err_deferred &&
    !(st_we && wr_data[resr_pkg::BIT_VALID])) |=> poison_flag)
    else $error("poison changed without new error");
  a_ns_hidden: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axil_arvalid && s_axil_arready && s_axil_arprot[1] && !nonsecure_reliability_access
    && s_axil_araddr == resr_pkg::ADDR_STATUS) |=> s_axil_rdata == 32'h0)
    else $error("nonsecure read leaked");
  a_ns_write_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_done && wr_ns && !nonsecure_reliability_access) |-> !st_we && !irq_en_we)
    else $error("nonsecure write not dropped");
  a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    err_deferred |=> postponed_flag)
    else $error("deferred set lost to clear");
  c_overflow: cover property (@(posedge aclk) disable iff (!aresetn) $rose(overflow_flag));
  c_clear_all: cover property (@(posedge aclk) disable iff (!aresetn) $fell(valid));
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  c_set_over_clear: cover property (@(posedge aclk) disable iff (!aresetn)
    st_we && err_uncorrected && wr_data[resr_pkg::BIT_UNFIXED]);
  c_ns_refused: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_done && wr_ns && !nonsecure_reliability_access);
endmodule
